// ===== inc/rivm_defs.vh
// Purpose : constants for the reset and interrupt vector map
// Assumes : word-addressed program memory, 32-bit apb data
// Notes   : included by rivm_top.v and rivm_prio.v
`ifndef RIVM_DEFS_VH
`define RIVM_DEFS_VH

// ----------------------------------------------------------------
// vector table shape
// ----------------------------------------------------------------
`define RIVM_NUM_VEC      35
`define RIVM_NUM_IRQ      34
`define RIVM_VEC_RESET    6'h01
`define RIVM_VEC_FIRST    6'h02
`define RIVM_VEC_WDT      6'h09
`define RIVM_SLOT_WORDS   16'h0002
`define RIVM_APP_BASE     16'h0000
`define RIVM_IDX_W        6

// ----------------------------------------------------------------
// request bit positions (bit i carries vector i+2)
// ----------------------------------------------------------------
`define RIVM_B_EXT0       0
`define RIVM_B_PCH0       3
`define RIVM_B_WDT        7
`define RIVM_B_T2         8
`define RIVM_B_T1         11
`define RIVM_B_T0         15
`define RIVM_B_SPI        18
`define RIVM_B_U0         19
`define RIVM_B_ACMP       22
`define RIVM_B_ADC        23
`define RIVM_B_EE         24
`define RIVM_B_TWS        25
`define RIVM_B_PST        26
`define RIVM_B_U1         27
`define RIVM_B_T3         30

// ----------------------------------------------------------------
// apb register map (byte addresses)
// ----------------------------------------------------------------
`define RIVM_A_CTRL       12'h000
`define RIVM_A_STAT       12'h004
`define RIVM_A_LAST       12'h008
`define RIVM_A_BOOT       12'h00C
`define RIVM_A_REQLO      12'h010
`define RIVM_A_REQHI      12'h014

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RIVM_F_VTSEL      0
`define RIVM_F_PVALID     8
`define RIVM_F_FUSE       9
`define RIVM_F_GIE        10
`define RIVM_CTRL_RST     1'b0

`endif

// ===== rtl/rivm_prio.v
// Purpose : lowest-index-wins priority encoder for pending requests
// Assumes : request vector already gated by global enable
// Notes   : purely combinational; one instance in rivm_top
`timescale 1ns/1ns
`include "rivm_defs.vh"

module rivm_prio #(
  parameter N   = `RIVM_NUM_IRQ,
  parameter W   = `RIVM_IDX_W
) (
  input  wire [N-1:0] req,
  output reg          found,
  output reg  [W-1:0] idx
);

  integer i;

  // ----------------------------------------------------------------
  // scan downwards so the lowest set bit is the last to win
  // ----------------------------------------------------------------
  always @* begin
    found = 1'b0;
    idx   = {W{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        found = 1'b1;
        idx   = i[W-1:0];
      end
    end
  end

endmodule // rivm_prio

// ===== rtl/rivm_top.v
// Purpose : reset and interrupt vector address generator
// Assumes : one clock pclk, async active-low presetn, apb slave
// Notes   : requests arrive already flagged and enabled per source
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "rivm_defs.vh"

module rivm_top #(
  parameter AW = 16
) (
  input  wire          pclk,
  input  wire          presetn,
  // apb slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata_ff,
  output reg           pready_ff,
  output reg           pslverr_ff,
  // configuration straps
  input  wire          boot_reset_select_fuse,
  input  wire [AW-1:0] boot_reset_addr,
  // core side
  input  wire          global_irq_enable,
  input  wire          core_vec_take,
  input  wire          wdt_reset_mode,
  output reg           reset_go_ff,
  output reg  [AW-1:0] reset_addr_ff,
  output reg           vec_valid_ff,
  output reg  [5:0]    vec_num_ff,
  output reg  [AW-1:0] vec_addr_ff,
  output reg           watchdog_flag_clr_ff,
  output reg           watchdog_irq_enable_clr_ff,
  // peripheral requests
  input  wire          external_request_zero,
  input  wire          external_request_one,
  input  wire          external_request_two,
  input  wire          pin_change_request_zero,
  input  wire          pin_change_request_one,
  input  wire          pin_change_request_two,
  input  wire          pin_change_request_three,
  input  wire          watchdog_timeout_flag,
  input  wire          t2_cmp_a,
  input  wire          t2_cmp_b,
  input  wire          t2_ovf,
  input  wire          t1_capture,
  input  wire          t1_cmp_a,
  input  wire          t1_cmp_b,
  input  wire          t1_ovf,
  input  wire          t0_cmp_a,
  input  wire          t0_cmp_b,
  input  wire          t0_ovf,
  input  wire          serial_xfer_done,
  input  wire          first_usart_rx_done,
  input  wire          first_usart_tx_empty,
  input  wire          first_usart_tx_done,
  input  wire          analog_compare,
  input  wire          conversion_done,
  input  wire          data_eeprom_ready,
  input  wire          two_wire_serial,
  input  wire          program_store_ready,
  input  wire          second_usart_rx_done,
  input  wire          second_usart_tx_empty,
  input  wire          second_usart_tx_done,
  input  wire          t3_capture,
  input  wire          t3_cmp_a,
  input  wire          t3_cmp_b,
  input  wire          t3_ovf
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // slot address of vector n over a table base
  function [AW-1:0] slot_addr;
    input [5:0]    n;
    input [AW-1:0] base;
    reg   [AW-1:0] off;
    begin
      off       = {{(AW-6){1'b0}}, (n - `RIVM_VEC_RESET)};
      slot_addr = base + off * `RIVM_SLOT_WORDS;
    end
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam ST_RESET = 2'b00;
  localparam ST_BOOT  = 2'b01;
  localparam ST_RUN   = 2'b10;

  reg  [1:0]    state_ff;
  reg  [1:0]    nxt_state;
  reg           fuse_ff;
  reg  [AW-1:0] boot_ff;
  reg           vtab_sel_ff;
  reg           nxt_vtab_sel;
  reg  [5:0]    last_ff;
  reg  [31:0]   nxt_prdata;
  reg           nxt_pslverr;
  wire          nxt_pready;
  wire          wr_go;
  wire [`RIVM_NUM_IRQ-1:0] req_raw;
  wire [`RIVM_NUM_IRQ-1:0] req_en;
  wire          pend_found;
  wire [5:0]    pend_idx;
  wire [5:0]    pend_num;
  wire [AW-1:0] vec_base;
  wire          take_go;

  // ----------------------------------------------------------------
  // request assembly
  // ----------------------------------------------------------------
  // bit i of the vector serves vector i+2
  assign req_raw[`RIVM_B_EXT0+2:`RIVM_B_EXT0] =
    {external_request_two, external_request_one,
     external_request_zero};
  assign req_raw[`RIVM_B_PCH0+3:`RIVM_B_PCH0] =
    {pin_change_request_three, pin_change_request_two,
     pin_change_request_one, pin_change_request_zero};
  assign req_raw[`RIVM_B_WDT] = watchdog_timeout_flag;
  assign req_raw[`RIVM_B_T2+2:`RIVM_B_T2] =
    {t2_ovf, t2_cmp_b, t2_cmp_a};
  assign req_raw[`RIVM_B_T1+3:`RIVM_B_T1] =
    {t1_ovf, t1_cmp_b, t1_cmp_a, t1_capture};
  assign req_raw[`RIVM_B_T0+2:`RIVM_B_T0] =
    {t0_ovf, t0_cmp_b, t0_cmp_a};
  assign req_raw[`RIVM_B_SPI] = serial_xfer_done;
  assign req_raw[`RIVM_B_U0+2:`RIVM_B_U0] =
    {first_usart_tx_done, first_usart_tx_empty,
     first_usart_rx_done};
  assign req_raw[`RIVM_B_ACMP] = analog_compare;
  assign req_raw[`RIVM_B_ADC]  = conversion_done;
  assign req_raw[`RIVM_B_EE]   = data_eeprom_ready;
  assign req_raw[`RIVM_B_TWS]  = two_wire_serial;
  assign req_raw[`RIVM_B_PST]  = program_store_ready;
  assign req_raw[`RIVM_B_U1+2:`RIVM_B_U1] =
    {second_usart_tx_done, second_usart_tx_empty,
     second_usart_rx_done};
  assign req_raw[`RIVM_B_T3+3:`RIVM_B_T3] =
    {t3_ovf, t3_cmp_b, t3_cmp_a, t3_capture};

  // nothing is offered before the reset vector has gone out
  assign req_en = (global_irq_enable && state_ff == ST_RUN) ?
                  req_raw : {`RIVM_NUM_IRQ{1'b0}};

  // ----------------------------------------------------------------
  // priority pick
  // ----------------------------------------------------------------
  rivm_prio #(
    .N   (`RIVM_NUM_IRQ),
    .W   (`RIVM_IDX_W)
  ) u_prio (
    .req   (req_en),
    .found (pend_found),
    .idx   (pend_idx)
  );

  assign pend_num = pend_idx + `RIVM_VEC_FIRST;

  // relocation base follows the select bit only, never the fuse
  assign vec_base = vtab_sel_ff ? boot_ff : `RIVM_APP_BASE;

  // core executes the vector it was shown
  assign take_go = core_vec_take && vec_valid_ff;

  // ----------------------------------------------------------------
  // reset sequencing
  // ----------------------------------------------------------------
  // straps are caught one edge after release, never under reset
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RESET: begin
        nxt_state = ST_BOOT;
      end
      ST_BOOT: begin
        nxt_state = ST_RUN;
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_RESET;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // strap capture in the first cycle after release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_ff <= 1'b1;
      boot_ff <= {AW{1'b0}};
    end else if (state_ff == ST_RESET) begin
      fuse_ff <= boot_reset_select_fuse;
      boot_ff <= boot_reset_addr;
    end
  end

  // reset vector: one pulse with the chosen start address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_go_ff   <= 1'b0;
      reset_addr_ff <= `RIVM_APP_BASE;
    end else begin
      reset_go_ff <= (state_ff == ST_BOOT);
      if (state_ff == ST_BOOT) begin
        // fuse 0 = programmed, selects boot loader start
        reset_addr_ff <= fuse_ff ? `RIVM_APP_BASE
                                 : boot_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // vector presentation
  // ----------------------------------------------------------------
  // re-evaluated every cycle; a higher request that lands late
  // still displaces the shown one until the core takes it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_valid_ff <= 1'b0;
      vec_num_ff   <= 6'h00;
      vec_addr_ff  <= {AW{1'b0}};
    end else if (take_go) begin
      // one dead cycle lets the served flag drop first
      vec_valid_ff <= 1'b0;
    end else begin
      vec_valid_ff <= pend_found;
      if (pend_found) begin
        vec_num_ff  <= pend_num;
        vec_addr_ff <= slot_addr(pend_num, vec_base);
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdog flag housekeeping
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_flag_clr_ff       <= 1'b0;
      watchdog_irq_enable_clr_ff <= 1'b0;
    end else begin
      watchdog_flag_clr_ff <= take_go &&
        (vec_num_ff == `RIVM_VEC_WDT);
      // combined mode drops back to plain reset mode
      watchdog_irq_enable_clr_ff <= take_go &&
        (vec_num_ff == `RIVM_VEC_WDT) &&
        wdt_reset_mode;
    end
  end

  // last vector executed, for software inspection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_ff <= 6'h00;
    end else if (reset_go_ff) begin
      last_ff <= `RIVM_VEC_RESET;
    end else if (take_go) begin
      last_ff <= vec_num_ff;
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // answer is prepared in setup, so every access has one wait-free
  // access cycle; pready falls again right after
  assign nxt_pready = psel && !penable;
  assign wr_go      = psel && penable && pready_ff && pwrite;

  // read mux and error decode on the setup cycle
  always @* begin
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    if (paddr == `RIVM_A_CTRL) begin
      nxt_prdata[`RIVM_F_VTSEL] = vtab_sel_ff;
    end else if (paddr == `RIVM_A_STAT) begin
      nxt_prdata[5:0]            = vec_num_ff;
      nxt_prdata[`RIVM_F_PVALID] = vec_valid_ff;
      nxt_prdata[`RIVM_F_FUSE]   = fuse_ff;
      nxt_prdata[`RIVM_F_GIE]    = global_irq_enable;
    end else if (paddr == `RIVM_A_LAST) begin
      nxt_prdata[5:0] = last_ff;
    end else if (paddr == `RIVM_A_BOOT) begin
      nxt_prdata[AW-1:0] = boot_ff;
    end else if (paddr == `RIVM_A_REQLO) begin
      nxt_prdata = req_raw[31:0];
    end else if (paddr == `RIVM_A_REQHI) begin
      nxt_prdata[1:0] = req_raw[`RIVM_NUM_IRQ-1:32];
    end else begin
      nxt_pslverr = 1'b1;   // unmapped
    end
    // only the control word is writable
    if (pwrite && paddr != `RIVM_A_CTRL) begin
      nxt_pslverr = 1'b1;
    end
    if (pwrite) begin
      nxt_prdata = 32'h0000_0000;
    end
  end

  // control register write, taken at the access edge only
  always @* begin
    nxt_vtab_sel = vtab_sel_ff;
    if (wr_go && paddr == `RIVM_A_CTRL) begin
      nxt_vtab_sel = pwdata[`RIVM_F_VTSEL];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vtab_sel_ff <= `RIVM_CTRL_RST;
      pready_ff   <= 1'b0;
      prdata_ff   <= 32'h0000_0000;
      pslverr_ff  <= 1'b0;
    end else begin
      vtab_sel_ff <= nxt_vtab_sel;
      pready_ff   <= nxt_pready;
      prdata_ff   <= nxt_pready ? nxt_prdata  : 32'h0000_0000;
      pslverr_ff  <= nxt_pready ? nxt_pslverr : 1'b0;
    end
  end

endmodule // rivm_top

// ===== sim/rivm_core_model.sv
// Purpose: core fetch stand-in that takes offered vectors
// Assumes: one take pulse per offer, after a chosen stall
// Notes  : hold keeps it busy so that requests can pile up
`timescale 1ns/1ns
module rivm_core_model (
  input  logic       pclk,
  input  logic       presetn,
  input  logic       hold,
  input  logic       vec_valid_ff,
  input  logic [3:0] stall,
  output logic       core_vec_take
);
  logic [3:0] wait_ff;
  // stall restarts on every new offer; a slow core may wait long
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_vec_take <= 1'b0;
      wait_ff       <= 4'h0;
    end else if (core_vec_take || hold || !vec_valid_ff) begin
      core_vec_take <= 1'b0;
      wait_ff       <= 4'h0;
    end else if (wait_ff >= stall) begin
      core_vec_take <= 1'b1;
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule // rivm_core_model

// ===== sim/rivm_top_properties.sv
// Purpose: port checks for the vector map block
// Assumes: straps steady between resets, default AW of 16
// Notes  : bound into rivm_top at the foot of this file
`timescale 1ns/1ns
module rivm_chk (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pready_ff,
  input logic        boot_reset_select_fuse,
  input logic        global_irq_enable,
  input logic        core_vec_take,
  input logic        wdt_reset_mode,
  input logic        reset_go_ff,
  input logic        vec_valid_ff,
  input logic        watchdog_flag_clr_ff,
  input logic        watchdog_irq_enable_clr_ff,
  input logic [15:0] boot_reset_addr,
  input logic [15:0] reset_addr_ff,
  input logic [15:0] vec_addr_ff,
  input logic [5:0]  vec_num_ff
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic        wdt_take_ff;
  wire         nxt_wdt_take = core_vec_take && vec_valid_ff &&
                              vec_num_ff == 6'h09;
  // slot offset, two words per vector
  wire  [15:0] off = {9'h000, vec_num_ff, 1'b0} - 16'h0002;
  // watchdog take kept one cycle to pair with the clear pulses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) wdt_take_ff <= 1'b0;
    else wdt_take_ff <= nxt_wdt_take;
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  apb_ready_a: assert property (psel && !penable |=> pready_ff)
    else $error("no ready after setup");
  reset_pulse_a: assert property (reset_go_ff |=> !reset_go_ff)
    else $error("reset pulse too long");
  reset_addr_a: assert property (reset_go_ff |->
    reset_addr_ff == (boot_reset_select_fuse ? 16'h0000 : boot_reset_addr))
    else $error("wrong reset address");
  vec_addr_a: assert property (
    vec_valid_ff |-> vec_addr_ff == off ||
    vec_addr_ff == boot_reset_addr + off) else $error("wrong vector address");
  vec_range_a: assert property (
    vec_valid_ff |-> vec_num_ff inside {[6'h02:6'h23]})
    else $error("vector number out of table");
  take_gap_a: assert property (
    core_vec_take && vec_valid_ff |=> !vec_valid_ff)
    else $error("offer not dropped after take");
  wdt_clr_a: assert property (nxt_wdt_take |=> watchdog_flag_clr_ff &&
    watchdog_irq_enable_clr_ff == $past(wdt_reset_mode))
    else $error("watchdog clear pulses wrong");
  clr_cause_a: assert property (
    watchdog_flag_clr_ff || watchdog_irq_enable_clr_ff |-> wdt_take_ff)
    else $error("watchdog clear without take");
  gie_off_a: assert property (!global_irq_enable [*2] |=> !vec_valid_ff)
    else $error("vector offered while disabled");
  cover property (nxt_wdt_take && wdt_reset_mode);
  cover property (reset_go_ff && !boot_reset_select_fuse);
  cover property (vec_valid_ff && vec_addr_ff != off);
endmodule // rivm_chk
bind rivm_top rivm_chk u_chk (.*);

// ===== sim/tb_reset_interrupt_vector_map.sv
// Purpose: self-checking bench for the vector map block
// Assumes: apb answers in one access cycle, default AW
// Notes  : request bit i stands for vector i+2
`timescale 1ns/1ns
module tb_reset_interrupt_vector_map;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, fuse = 1'b1, gie = 1'b1, wmode = 1'b0;
  logic        hold = 1'b0, take, err, pready_ff, pslverr_ff, wclr, eclr;
  logic        reset_go_ff, vec_valid_ff;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 0, prdata_ff, rd, lfsr_ff = 32'hca4d;
  logic [15:0] boot = 16'hf000, reset_addr_ff, vec_addr_ff;
  logic [5:0]  vec_num_ff;
  logic [33:0] rq = 0;
  logic [3:0]  stall = 4'h0;
  int          bad_count = 0, checks_done = 0;

  rivm_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .boot_reset_select_fuse(fuse), .boot_reset_addr(boot),
    .global_irq_enable(gie), .core_vec_take(take), .wdt_reset_mode(wmode),
    .reset_go_ff(reset_go_ff), .reset_addr_ff(reset_addr_ff),
    .vec_valid_ff(vec_valid_ff), .vec_num_ff(vec_num_ff),
    .vec_addr_ff(vec_addr_ff), .watchdog_flag_clr_ff(wclr),
    .watchdog_irq_enable_clr_ff(eclr),
    .external_request_zero(rq[0]), .external_request_one(rq[1]),
    .external_request_two(rq[2]), .pin_change_request_zero(rq[3]),
    .pin_change_request_one(rq[4]), .pin_change_request_two(rq[5]),
    .pin_change_request_three(rq[6]), .watchdog_timeout_flag(rq[7]),
    .t2_cmp_a(rq[8]), .t2_cmp_b(rq[9]), .t2_ovf(rq[10]),
    .t1_capture(rq[11]), .t1_cmp_a(rq[12]), .t1_cmp_b(rq[13]),
    .t1_ovf(rq[14]), .t0_cmp_a(rq[15]), .t0_cmp_b(rq[16]),
    .t0_ovf(rq[17]), .serial_xfer_done(rq[18]),
    .first_usart_rx_done(rq[19]), .first_usart_tx_empty(rq[20]),
    .first_usart_tx_done(rq[21]), .analog_compare(rq[22]),
    .conversion_done(rq[23]), .data_eeprom_ready(rq[24]),
    .two_wire_serial(rq[25]), .program_store_ready(rq[26]),
    .second_usart_rx_done(rq[27]), .second_usart_tx_empty(rq[28]),
    .second_usart_tx_done(rq[29]), .t3_capture(rq[30]),
    .t3_cmp_a(rq[31]), .t3_cmp_b(rq[32]), .t3_ovf(rq[33])
  );
  rivm_core_model u_core (.pclk(pclk), .presetn(presetn), .hold(hold),
    .vec_valid_ff(vec_valid_ff), .stall(stall), .core_vec_take(take));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    forever #50 pclk = ~pclk;
  end
  // hang guard, far beyond the few thousand cycles needed
  initial begin
    #4_000_000;
    bad_count++;
    wrap_up();
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one apb transfer; held until ready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the hang guard ends this wait
    do begin
      @(posedge pclk);
    end while (pready_ff !== 1'b1);
    rd  = prdata_ff;
    err = pslverr_ff;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset(input logic f);
    int n;
    @(posedge pclk);
    presetn <= 1'b0;
    fuse    <= f;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (reset_go_ff !== 1'b1 && n < 8);
    chk_val(n, 3);
    chk_val(reset_addr_ff, f ? 16'h0000 : boot);
  endtask
  // model: lowest pending request wins, slot = base + 2(n-1)
  task automatic serve(input logic [15:0] bs);
    int n, e;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (!(take === 1'b1 && vec_valid_ff === 1'b1) && n < 40);
    chk_val(n < 40, 1);
    e = 0;
    while (e < 34 && rq[e] !== 1'b1) e++;
    chk_val(vec_num_ff, e + 2);
    chk_val(vec_addr_ff, bs + 2 * (e + 1));
    @(posedge pclk);
    rq[e] <= 1'b0;
    @(negedge pclk);
    chk_val(wclr, e == 7);
    chk_val(eclr, e == 7 && wmode);
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    do_reset(1'b0);
    do_reset(1'b1);
    $display("reset test done");
    apb(1'b0, 12'h000, 0);
    chk_val(rd, 0);
    apb(1'b0, 12'h00C, 0);
    chk_val(rd, boot);
    apb(1'b0, 12'h008, 0);
    chk_val(rd, 1);
    apb(1'b1, 12'h004, 1);
    chk_val(err, 1);
    apb(1'b0, 12'h020, 0);
    chk_val(err, 1);
    $display("register test done");
    // every source alone, with the table at zero and then relocated
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, 12'h000, s);
      wmode <= s[0];
      apb(1'b0, 12'h000, 0);
      chk_val(rd, s);
      for (int i = 0; i < 34; i++) begin
        @(posedge pclk);
        rq[i] <= 1'b1;
        serve(s ? boot : 16'h0000);
      end
    end
    $display("map test done");
    @(posedge pclk);
    gie   <= 1'b0;
    rq[8] <= 1'b1;
    repeat (6) @(negedge pclk);
    chk_val(vec_valid_ff, 0);
    // status keeps the last shown vector 35, fuse 1, enable 0
    apb(1'b0, 12'h004, 0);
    chk_val(rd, 32'h0000_0223);
    apb(1'b0, 12'h008, 0);
    chk_val(rd, 32'h0000_0023);
    apb(1'b0, 12'h010, 0);
    chk_val(rd, 32'h0000_0100);
    @(posedge pclk);
    gie <= 1'b1;
    serve(boot);
    $display("gate test done");
    // piles of random requests drained by a randomly slow core
    for (int r = 0; r < 8; r++) begin
      @(posedge pclk);
      lfsr_ff = lfsr(lfsr_ff);
      hold  <= 1'b1;
      rq    <= {lfsr_ff[31:30], lfsr_ff};
      stall <= lfsr_ff[7:4];
      repeat (3) @(posedge pclk);
      hold <= 1'b0;
      while (rq != 0) serve(boot);
    end
    $display("priority test done");
    wrap_up();
  end
endmodule // tb_reset_interrupt_vector_map
